// File: pir_pkg.sv
// Shared constants and types for the package idle state resolver
package pir_pkg;

  // Package and core idle states, shallowest first
  typedef enum logic [2:0] {
    PIR_C0,
    PIR_C1,
    PIR_C1E,
    PIR_C2,
    PIR_C3,
    PIR_C6,
    PIR_C7
  } pir_cstate_t;

  // Width of one state code
  localparam int PIR_SW = 3;

  // Register byte offsets
  localparam logic [3:0] PIR_CFG_OFS = 4'h0;
  localparam logic [3:0] PIR_STAT_OFS = 4'h4;

  // Config field positions
  localparam int PIR_CFG_C1E_BIT = 0;
  localparam int PIR_CFG_PROMO_BIT = 1;
  localparam int PIR_CFG_HEUR_BIT = 2;
  localparam int PIR_CFG_LIM_LSB = 4;

  // Status field positions
  localparam int PIR_ST_PKG_LSB = 0;
  localparam int PIR_ST_PREV_LSB = 4;
  localparam int PIR_ST_BRK_BIT = 8;
  localparam int PIR_ST_MEM_BIT = 9;
  localparam int PIR_ST_FLUSH_BIT = 10;

  // Config reset values
  localparam logic PIR_C1E_RST = 1'b0;
  localparam logic PIR_PROMO_RST = 1'b0;
  localparam logic PIR_HEUR_RST = 1'b0;

  // Heuristic residency hold, in ns, and clock period
  localparam int PIR_CLK_NS = 10;
  localparam int PIR_RESID_NS = 2000;
  localparam int PIR_RESID_CYC = (PIR_RESID_NS + PIR_CLK_NS - 1) / PIR_CLK_NS;

endpackage

// File: pir_package_idle_state_resolver.sv
// Package idle state resolver with Avalon-MM register slave
//
// Function
// - Package request is shallowest core state
// - Cores may sit deeper than package
// - Any idle state reachable directly, skipping C0
// - Heuristic may hold package deeper than asked
// - Core break wakes core, forwards message
// - Unmasked break forces core and package active
// - Masked break returns package to prior state
// - Memory break serviced, then previous state restored
// - Platform shallow request during memory break sticks
// - Enhanced enabled gives C1E when all C1+
// - No platform grant keeps package active
// - C1E lowers frequency first, voltage after
// - C1E on all hints or promoted halts
// - Depth limit at C1/C1E with deeper cores gives C1E
// - No system notification on C1/C1E entry
// - C2 when deep requested but constraints forbid
// - Memory access from C3+ goes C2, returns
// - C3 keeps last-level cache valid when granted
// - C6 when granted; cores saved, unpowered
// - No flush if C6 asked; flush if C7 limited
// - C7 entered only when all cores C7
// - Internal choice between C6 and C7
`timescale 1ns/1ps

module pir_package_idle_state_resolver #(
  parameter int NUM_CORES = 2,
  parameter int RESID_CYC = pir_pkg::PIR_RESID_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core requests, one state code per core
  input wire logic [NUM_CORES*pir_pkg::PIR_SW-1:0] core_state,
  input wire logic [NUM_CORES-1:0] core_c1e_hint,
  input wire logic gfx_deep_req,
  input wire logic display_active,
  // Platform permission and constraints
  input wire logic [2:0] plat_grant,
  input wire logic latency_hold,
  input wire logic plat_shallow_req,
  input wire logic [2:0] plat_shallow_state,
  // Break events
  input wire logic core_brk,
  input wire logic [7:0] core_brk_id,
  input wire logic core_brk_masked,
  input wire logic mem_req,
  input wire logic mem_busy,
  // Package state and power actions
  output logic [2:0] pkg_state,
  output logic freq_min,
  output logic volt_low,
  output logic llc_flush,
  output logic core_power_off,
  output logic sa_power_off,
  output logic [NUM_CORES-1:0] core_wake,
  output logic brk_msg_valid,
  output logic [7:0] brk_msg_id
);

  // Break sequencing phases
  typedef enum logic [1:0] {
    PIR_RUN,
    PIR_WAKE,
    PIR_MEM
  } pir_phase_t;

  // Shallower of two states
  function automatic pir_pkg::pir_cstate_t pir_min(
    input pir_pkg::pir_cstate_t a,
    input pir_pkg::pir_cstate_t b
  );
    pir_min = (a < b) ? a : b;
  endfunction

  // Shallowest core state across all cores
  function automatic pir_pkg::pir_cstate_t pir_core_min(
    input logic [NUM_CORES*pir_pkg::PIR_SW-1:0] v
  );
    pir_pkg::pir_cstate_t m;
    m = pir_pkg::PIR_C7;
    for (int i = 0; i < NUM_CORES; i++) begin
      m = pir_min(m, pir_pkg::pir_cstate_t'(v[i*pir_pkg::PIR_SW +: pir_pkg::PIR_SW]));
    end
    pir_core_min = m;
  endfunction

  // Registered state
  pir_pkg::pir_cstate_t pkg_reg, pkg_next; // Current package state
  pir_pkg::pir_cstate_t prev_reg; // State before a break
  pir_phase_t phase_reg; // Break phase
  logic brk_mask_reg; // Break was masked
  logic c1e_en_reg; // Enhanced C1 enable
  logic promo_en_reg; // Halt auto-promotion enable
  logic heur_en_reg; // Deeper-hold heuristic enable
  logic [2:0] lim_reg; // Package depth limit config
  logic [15:0] resid_reg; // Heuristic residency counter
  logic freq_min_reg; // Frequency at minimum
  logic volt_low_reg; // Voltage lowered
  logic flush_reg; // Shared cache flushed
  logic core_off_reg; // Core voltage removed
  logic sa_off_reg; // System agent partly off
  logic [NUM_CORES-1:0] wake_reg; // Core wake pulses
  logic msg_v_reg; // Break message valid
  logic [7:0] msg_id_reg; // Break message target
  logic [31:0] rdata_reg; // Bus read data
  logic wait_reg; // Bus waitrequest

  // Resolution terms
  pir_pkg::pir_cstate_t req_min; // Shallowest core request
  pir_pkg::pir_cstate_t limit; // Effective depth cap
  pir_pkg::pir_cstate_t resolved; // Resolved target
  logic all_hint; // Every core hinted C1E
  logic all_c7; // Every core asks C7
  logic any_c6; // Some core asks exactly C6
  logic bus_req; // Bus request present
  logic sel_cfg; // Config register addressed
  logic sel_stat; // Status register addressed
  // Core summaries
  always_comb begin
    all_c7 = 1'b1;
    any_c6 = 1'b0;
    for (int i = 0; i < NUM_CORES; i++) begin
      if (core_state[i*pir_pkg::PIR_SW +: pir_pkg::PIR_SW] != pir_pkg::PIR_C7) begin
        all_c7 = 1'b0;
      end
      if (core_state[i*pir_pkg::PIR_SW +: pir_pkg::PIR_SW] == pir_pkg::PIR_C6) begin
        any_c6 = 1'b1;
      end
    end
    all_hint = &core_c1e_hint;
    req_min = pir_core_min(core_state);
    // A platform shallow request caps the depth for as long as it stands
    limit = pir_min(pir_min(pir_pkg::pir_cstate_t'(plat_grant), pir_pkg::pir_cstate_t'(lim_reg)),
                    plat_shallow_req ? pir_pkg::pir_cstate_t'(plat_shallow_state) : pir_pkg::PIR_C7);
  end
  // Idle resolution from core requests and platform limits
  always_comb begin
    resolved = pir_pkg::PIR_C0;
    if (limit == pir_pkg::PIR_C0 || req_min == pir_pkg::PIR_C0) begin
      // No permission: stay active even with idle cores
      resolved = pir_pkg::PIR_C0;
    end else if (req_min <= pir_pkg::PIR_C1E) begin
      // Halted cores: plain C1 unless enhanced sub-state applies
      if (c1e_en_reg && (all_hint || promo_en_reg)) begin
        resolved = pir_pkg::PIR_C1E;
      end else begin
        resolved = pir_pkg::PIR_C1;
      end
    end else if (limit <= pir_pkg::PIR_C1E) begin
      // Deep cores but package capped at C1/C1E
      resolved = pir_pkg::PIR_C1E;
    end else if (latency_hold || !gfx_deep_req || limit == pir_pkg::PIR_C2) begin
      // Deep requested, constraints forbid going past C2
      resolved = pir_pkg::PIR_C2;
    end else begin
      // Package never deeper than the shallowest core
      resolved = pir_min(req_min, limit);
      if (resolved == pir_pkg::PIR_C7 && display_active) begin
        // C6 is cheaper while the display fetches
        resolved = pir_pkg::PIR_C6;
      end
    end
  end

  // Next package state, including break handling
  always_comb begin
    pkg_next = pkg_reg;
    case (phase_reg)
      PIR_RUN: begin
        if (core_brk) begin
          // Leave idle while the message goes to the core
          pkg_next = pir_pkg::PIR_C0;
        end else if (mem_req && pkg_reg >= pir_pkg::PIR_C3) begin
          // Memory must be reachable: open up to C2
          pkg_next = pir_pkg::PIR_C2;
        end else if (heur_en_reg && pkg_reg > resolved && resolved >= pir_pkg::PIR_C3 &&
                     pkg_reg <= limit && resid_reg != 16'h0000) begin
          // Hold deeper until minimum residency expires
          pkg_next = pkg_reg;
        end else begin
          // Direct move, no pass through C0
          pkg_next = resolved;
        end
      end
      PIR_WAKE: begin
        if (brk_mask_reg) begin
          // Masked: attempt the earlier state
          pkg_next = pir_min(prev_reg, resolved);
        end else begin
          pkg_next = pir_pkg::PIR_C0;
        end
      end
      PIR_MEM: begin
        if (!mem_busy) begin
          if (plat_shallow_req) begin
            // Platform wants more power: settle there, within the grant
            pkg_next = pir_min(pir_min(prev_reg, pir_pkg::pir_cstate_t'(plat_shallow_state)), resolved);
          end else begin
            pkg_next = pir_min(prev_reg, resolved);
          end
        end
      end
      default: begin
        pkg_next = pir_pkg::PIR_C0;
      end
    endcase
  end
  // Package state register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pkg_reg <= pir_pkg::PIR_C0;
    end else begin
      pkg_reg <= pkg_next;
    end
  end
  // Break phase and saved state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_reg <= PIR_RUN;
      prev_reg <= pir_pkg::PIR_C0;
      brk_mask_reg <= 1'b0;
    end else begin
      case (phase_reg)
        PIR_RUN: begin
          if (core_brk) begin
            phase_reg <= PIR_WAKE;
            prev_reg <= pkg_reg;
            brk_mask_reg <= core_brk_masked;
          end else if (mem_req && pkg_reg >= pir_pkg::PIR_C3) begin
            phase_reg <= PIR_MEM;
            prev_reg <= pkg_reg;
          end
        end
        PIR_WAKE: begin
          // One cycle to deliver the message
          phase_reg <= PIR_RUN;
        end
        PIR_MEM: begin
          // Wait for every outstanding request
          if (!mem_busy) begin
            phase_reg <= PIR_RUN;
          end
        end
        default: begin
          phase_reg <= PIR_RUN;
        end
      endcase
    end
  end
  // Residency counter, reloaded on each change of state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resid_reg <= 16'h0000;
    end else if (pkg_next != pkg_reg) begin
      resid_reg <= 16'(RESID_CYC);
    end else if (resid_reg != 16'h0000) begin
      resid_reg <= resid_reg - 16'h0001;
    end
  end

  // Break message and core wake pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_reg <= '0;
      msg_v_reg <= 1'b0;
      msg_id_reg <= 8'h00;
    end else begin
      wake_reg <= '0;
      msg_v_reg <= 1'b0;
      if (phase_reg == PIR_RUN && core_brk) begin
        // Activate only the target core
        for (int i = 0; i < NUM_CORES; i++) begin
          wake_reg[i] <= (core_brk_id == 8'(i));
        end
        msg_v_reg <= 1'b1;
        msg_id_reg <= core_brk_id;
      end
    end
  end
  // C1E entry: frequency drops first, voltage follows
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      freq_min_reg <= 1'b0;
      volt_low_reg <= 1'b0;
    end else begin
      freq_min_reg <= (pkg_next == pir_pkg::PIR_C1E);
      volt_low_reg <= freq_min_reg && (pkg_next == pir_pkg::PIR_C1E);
    end
  end
  // Power actions for the deep states
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flush_reg <= 1'b0;
      core_off_reg <= 1'b0;
      sa_off_reg <= 1'b0;
    end else begin
      // No system notification output exists for C1/C1E
      core_off_reg <= (pkg_next >= pir_pkg::PIR_C6);
      sa_off_reg <= (pkg_next == pir_pkg::PIR_C7);
      // C3 keeps the cache; C6 flushes only if no core asks C6
      if (pkg_next == pir_pkg::PIR_C7) begin
        flush_reg <= 1'b1;
      end else if (pkg_next == pir_pkg::PIR_C6) begin
        flush_reg <= all_c7 && !any_c6;
      end else begin
        flush_reg <= 1'b0;
      end
    end
  end

  // Bus decode
  always_comb begin
    bus_req = avs_read || avs_write;
    sel_cfg = 1'b0;
    sel_stat = 1'b0;
    if (avs_address == pir_pkg::PIR_CFG_OFS) begin
      sel_cfg = 1'b1;
    end else if (avs_address == pir_pkg::PIR_STAT_OFS) begin
      sel_stat = 1'b1;
    end
  end

  // Waitrequest: one wait cycle, then complete
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else if (bus_req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data captured in the wait cycle; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= 32'h00000000;
      if (sel_cfg) begin
        rdata_reg[pir_pkg::PIR_CFG_C1E_BIT] <= c1e_en_reg;
        rdata_reg[pir_pkg::PIR_CFG_PROMO_BIT] <= promo_en_reg;
        rdata_reg[pir_pkg::PIR_CFG_HEUR_BIT] <= heur_en_reg;
        rdata_reg[pir_pkg::PIR_CFG_LIM_LSB +: 3] <= lim_reg;
      end else if (sel_stat) begin
        rdata_reg[pir_pkg::PIR_ST_PKG_LSB +: 3] <= pkg_reg;
        rdata_reg[pir_pkg::PIR_ST_PREV_LSB +: 3] <= prev_reg;
        rdata_reg[pir_pkg::PIR_ST_BRK_BIT] <= (phase_reg == PIR_WAKE);
        rdata_reg[pir_pkg::PIR_ST_MEM_BIT] <= (phase_reg == PIR_MEM);
        rdata_reg[pir_pkg::PIR_ST_FLUSH_BIT] <= flush_reg;
      end
    end
  end

  // Config writes land on the completing edge; others ignored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      c1e_en_reg <= pir_pkg::PIR_C1E_RST;
      promo_en_reg <= pir_pkg::PIR_PROMO_RST;
      heur_en_reg <= pir_pkg::PIR_HEUR_RST;
      lim_reg <= pir_pkg::PIR_C7;
    end else if (avs_write && !wait_reg && sel_cfg) begin
      c1e_en_reg <= avs_writedata[pir_pkg::PIR_CFG_C1E_BIT];
      promo_en_reg <= avs_writedata[pir_pkg::PIR_CFG_PROMO_BIT];
      heur_en_reg <= avs_writedata[pir_pkg::PIR_CFG_HEUR_BIT];
      // Codes past C7 clamp to C7
      if (avs_writedata[pir_pkg::PIR_CFG_LIM_LSB +: 3] > 3'(pir_pkg::PIR_C7)) begin
        lim_reg <= pir_pkg::PIR_C7;
      end else begin
        lim_reg <= avs_writedata[pir_pkg::PIR_CFG_LIM_LSB +: 3];
      end
    end
  end
  // Outputs straight from flops
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign pkg_state = pkg_reg;
  assign freq_min = freq_min_reg;
  assign volt_low = volt_low_reg;
  assign llc_flush = flush_reg;
  assign core_power_off = core_off_reg;
  assign sa_power_off = sa_off_reg;
  assign core_wake = wake_reg;
  assign brk_msg_valid = msg_v_reg;
  assign brk_msg_id = msg_id_reg;

endmodule // pir_package_idle_state_resolver

// File: pir_resolver_properties.sv
// Checker of package state resolution and register bus timing
`timescale 1ns/1ps

module pir_resolver_properties #(
  parameter int NUM_CORES = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Requests and events
  input wire logic [NUM_CORES*pir_pkg::PIR_SW-1:0] core_state,
  input wire logic [2:0] plat_grant,
  input wire logic core_brk,
  input wire logic [7:0] core_brk_id,
  input wire logic mem_req,
  input wire logic mem_busy,
  // Package outputs
  input wire logic [2:0] pkg_state,
  input wire logic freq_min,
  input wire logic volt_low,
  input wire logic llc_flush,
  input wire logic [NUM_CORES-1:0] core_wake,
  input wire logic brk_msg_valid,
  input wire logic [7:0] brk_msg_id
);
  logic any_c6; // Some core asks for C6

  // Flags a core in C6; flush must wait for them
  always_comb begin
    any_c6 = 1'b0;
    for (int i = 0; i < NUM_CORES; i++) begin
      any_c6 = any_c6 | (core_state[3*i+:3] == 3'h5);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Memory phase may hold C2, so it is kept out
  a_idle_no_grant: assert property (plat_grant == 3'h0 && !mem_busy && !mem_req |=> pkg_state == 3'h0)
    else $error("package left C0 without a grant");
  a_volt_after_freq: assert property ($rose(volt_low) |-> freq_min && $past(freq_min))
    else $error("voltage dropped before frequency");
  a_c1e_actions: assert property ($rose(pkg_state == 3'h2) |-> freq_min && !volt_low
    ##1 volt_low == (pkg_state == 3'h2))
    else $error("C1E entry without frequency then voltage step");
  a_break_forward: assert property (brk_msg_valid |-> $past(core_brk) && brk_msg_id == $past(core_brk_id)
    && pkg_state == 3'h0 && core_wake != '0)
    else $error("break message not tied to its event");
  a_wake_one_cycle: assert property (core_wake != '0 |-> brk_msg_valid ##1 core_wake == '0)
    else $error("core wake is not a single pulse");
  a_c7_all_cores: assert property ($changed(pkg_state) && pkg_state == 3'h6
    |-> $past(core_state) == {NUM_CORES{3'h6}})
    else $error("C7 entered with a core shallower");
  a_flush_policy: assert property (pkg_state == 3'h5 && llc_flush |-> !$past(any_c6))
    else $error("cache flushed while a core asks C6");
  a_mem_to_c2: assert property (mem_req && !core_brk && !brk_msg_valid && pkg_state >= 3'h4
    |=> pkg_state == 3'h3)
    else $error("memory access from deep state did not give C2");
  a_grant_bound: assert property ($changed(pkg_state) && pkg_state >= 3'h4
    |-> $past(plat_grant) >= pkg_state)
    else $error("deep state entered beyond the grant");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule // pir_resolver_properties

bind pir_package_idle_state_resolver pir_resolver_properties #(.NUM_CORES(NUM_CORES)) chk_u (.*);

// File: pir_platform_model.sv
// Platform controller model: grants package depth, asks for shallow hold
`timescale 1ns/1ps

module pir_platform_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench control
  input wire logic [2:0] want_grant,
  input wire logic want_shallow,
  input wire logic slow,
  // Platform outputs
  output logic [2:0] plat_grant,
  output logic plat_shallow_req,
  output logic [2:0] plat_shallow_state
);
  logic [2:0] lag_reg; // Grant one cycle late, for slow replies

  // Grant follows the request, promptly or late
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lag_reg <= 3'h0;
      plat_grant <= 3'h0;
    end else begin
      lag_reg <= want_grant;
      plat_grant <= slow ? lag_reg : want_grant;
    end
  end

  // Level churns when not asked, so a stale value cannot pass
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      plat_shallow_req <= 1'b0;
      plat_shallow_state <= 3'h0;
    end else begin
      plat_shallow_req <= want_shallow;
      plat_shallow_state <= want_shallow ? 3'h4 : plat_shallow_state + 3'h3;
    end
  end
endmodule // pir_platform_model

// File: pir_package_idle_state_resolver_test.sv
// Self-checking bench for the package idle state resolver
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected %s exp %0h got %0h", n, e, a); end end

module pir_package_idle_state_resolver_test;
  logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [5:0] core_state = 6'h0;
  logic [1:0] core_c1e_hint = 2'h0, core_wake;
  logic gfx_deep_req = 1'b1, display_active = 1'b0, latency_hold = 1'b0, plat_shallow_req, core_brk = 1'b0;
  logic [2:0] plat_grant, plat_shallow_state, want_grant = 3'h0, pkg_state, e, a, b, g;
  logic [7:0] core_brk_id = 8'h0, brk_msg_id;
  logic core_brk_masked = 1'b0, mem_req = 1'b0, mem_busy = 1'b0, want_shallow = 1'b0, slow = 1'b0;
  logic freq_min, volt_low, llc_flush, core_power_off, sa_power_off, brk_msg_valid, r_lat, r_gfx, r_disp;
  logic [2:0] pick [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6}; // Core codes C0 C1 C3 C6 C7
  logic [2:0] gpick [4] = '{3'h0, 3'h4, 3'h5, 3'h6}; // Grants none, C3, C6, C7
  int compares = 0, n_mismatch = 0;

  pir_package_idle_state_resolver #(.NUM_CORES(2), .RESID_CYC(4)) dut_u (.*);
  pir_platform_model plat_u (.clk_sys(clk_sys), .rst_n(rst_n), .want_grant(want_grant),
    .want_shallow(want_shallow), .slow(slow), .plat_grant(plat_grant), .plat_shallow_req(plat_shallow_req),
    .plat_shallow_state(plat_shallow_state));

  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Expected package state, config has C1E and promotion on
  function automatic logic [2:0] exp_pkg(input logic [2:0] a, b, g, l, input logic lat, gfx, disp);
    logic [2:0] m;
    logic [2:0] r;
    m = (a < b) ? a : b;
    r = (g < l) ? g : l;
    if (m == 3'h0 || g == 3'h0) return 3'h0;
    if (m < 3'h3 || r < 3'h3) return 3'h2;
    if (lat || !gfx || r == 3'h3) return 3'h3;
    r = (m < r) ? m : r;
    return (r == 3'h6 && disp) ? 3'h5 : r;
  endfunction

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge so a following call never rewrites the strobe in this step
    @(posedge clk_sys);
    if (n >= 20) begin
      n_mismatch++;
      final_report();
    end
  endtask

  // Cores and grant change, then let partner and design settle
  task automatic put(input logic [2:0] ca, cb, cg);
    core_state <= {cb, ca};
    want_grant <= cg;
    repeat (6) @(posedge clk_sys);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end

  initial begin
    void'($urandom(32'heff7));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 4'h0, 32'h0, q);
    `CHK("cfg reset", 32'h60, q)
    bus(1'b0, 4'hC, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    put(3'h1, 3'h1, 3'h6);
    `CHK("c1 plain", 3'h1, pkg_state)
    bus(1'b1, 4'h4, 32'h7, q);
    bus(1'b0, 4'h4, 32'h0, q);
    `CHK("status", 3'h1, q[2:0])
    bus(1'b1, 4'h0, 32'h63, q);
    // Random mix, each settle is a direct jump between states
    for (int i = 0; i < 60; i++) begin
      a = pick[$urandom % 5];
      b = pick[$urandom % 5];
      g = gpick[$urandom % 4];
      r_lat = 1'($urandom);
      r_gfx = 1'($urandom);
      r_disp = 1'($urandom);
      latency_hold <= r_lat;
      gfx_deep_req <= r_gfx;
      display_active <= r_disp;
      core_c1e_hint <= 2'($urandom);
      slow <= 1'($urandom);
      put(a, b, g);
      e = exp_pkg(a, b, g, 3'h6, r_lat, r_gfx, r_disp);
      `CHK("pkg", e, pkg_state)
      `CHK("fmin", e == 3'h2, freq_min)
      `CHK("sa off", e == 3'h6, sa_power_off)
      `CHK("core off", e >= 3'h5, core_power_off)
      `CHK("flush", e == 3'h6 || (e == 3'h5 && a == 3'h6 && b == 3'h6), llc_flush)
    end
    latency_hold <= 1'b0;
    gfx_deep_req <= 1'b1;
    display_active <= 1'b0;
    // Core break, masked then unmasked
    for (int m = 1; m >= 0; m--) begin
      put(3'h5, 3'h5, 3'h5);
      core_brk <= 1'b1;
      core_brk_id <= 8'h01;
      core_brk_masked <= m[0];
      @(posedge clk_sys);
      core_brk <= 1'b0;
      @(posedge clk_sys);
      `CHK("brk pkg", 3'h0, pkg_state)
      `CHK("wake", 2'b10, core_wake)
      `CHK("msg", 9'h101, {brk_msg_valid, brk_msg_id})
      @(posedge clk_sys);
      `CHK("after brk", (m == 1) ? 3'h5 : 3'h0, pkg_state)
    end
    // Memory break, plain then with platform shallow hold
    for (int s = 0; s < 2; s++) begin
      put(3'h5, 3'h5, 3'h5);
      mem_req <= 1'b1;
      mem_busy <= 1'b1;
      @(posedge clk_sys);
      mem_req <= 1'b0;
      // Platform asks for more power only once the break is under way
      want_shallow <= s[0];
      repeat (3) @(posedge clk_sys);
      `CHK("mem pkg", 3'h3, pkg_state)
      mem_busy <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK("mem back", (s == 1) ? 3'h4 : 3'h5, pkg_state)
      repeat (4) @(posedge clk_sys);
      `CHK("mem hold", (s == 1) ? 3'h4 : 3'h5, pkg_state)
    end
    want_shallow <= 1'b0;
    // Heuristic on: a fresh deep state outlives a shallower request
    bus(1'b1, 4'h0, 32'h67, q);
    put(3'h4, 3'h4, 3'h6);
    core_state <= 6'h36;
    @(posedge clk_sys);
    core_state <= 6'h24;
    repeat (3) @(posedge clk_sys);
    `CHK("held deep", 3'h6, pkg_state)
    repeat (6) @(posedge clk_sys);
    `CHK("hold ends", 3'h4, pkg_state)
    // Depth limit at C1E with deep cores
    bus(1'b1, 4'h0, 32'h23, q);
    put(3'h5, 3'h6, 3'h6);
    `CHK("limit c1e", exp_pkg(3'h5, 3'h6, 3'h6, 3'h2, 1'b0, 1'b1, 1'b0), pkg_state)
    `CHK("c1e steps", 2'b11, {freq_min, volt_low})
    bus(1'b1, 4'h0, 32'h73, q);
    bus(1'b0, 4'h0, 32'h0, q);
    `CHK("limit clamp", 32'h63, q)
    final_report();
  end
endmodule // pir_package_idle_state_resolver_test
